// ### inc/nsl_pkg.sv
`default_nettype none
package nsl_pkg;

   // i/o addresses of the four 8-bit ports
   localparam logic [15:0] NSL_SYS_CTRL_ADDR  = 16'h0061;
   localparam logic [15:0] NSL_NMI_MASK_ADDR  = 16'h0070;
   localparam logic [15:0] NSL_EXT_CTRL_ADDR  = 16'h0461;
   localparam logic [15:0] NSL_SW_TRIG_ADDR   = 16'h0462;

   // system control port bit positions
   localparam int NSL_SYS_PAR_STS_BIT = 7;
   localparam int NSL_SYS_CHK_STS_BIT = 6;
   localparam int NSL_SYS_CHK_DIS_BIT = 3;
   localparam int NSL_SYS_PAR_DIS_BIT = 2;

   // extended control port bit positions
   localparam int NSL_EXT_FS_STS_BIT  = 7;
   localparam int NSL_EXT_BT_STS_BIT  = 6;
   localparam int NSL_EXT_SW_STS_BIT  = 5;
   localparam int NSL_EXT_BT_DIS_BIT  = 3;
   localparam int NSL_EXT_FS_DIS_BIT  = 2;
   localparam int NSL_EXT_SW_DIS_BIT  = 1;
   localparam int NSL_EXT_BUS_RST_BIT = 0;

   // mask port: high blocks every source
   localparam int NSL_MASK_BIT = 7;

   // index of each source in the pending vector
   localparam int NSL_SRC_PAR = 0;
   localparam int NSL_SRC_CHK = 1;
   localparam int NSL_SRC_FS  = 2;
   localparam int NSL_SRC_BT  = 3;
   localparam int NSL_SRC_SW  = 4;
   localparam int NSL_SRC_NUM = 5;

   // values after reset
   localparam logic [3:0] NSL_SYS_CTRL_RST = 4'h0;
   localparam logic [3:0] NSL_EXT_CTRL_RST = 4'h0;
   localparam logic [7:0] NSL_NMI_MASK_RST = 8'h80;
   localparam logic [4:0] NSL_PEND_RST     = 5'h00;

   // timing, in ns, and derived cycle counts (least times round up)
   localparam int NSL_CLK_PERIOD_NS  = 100;
   localparam int NSL_MASTER_TMO_NS  = 8000;
   localparam int NSL_CMD_TMO_NS     = 32000;
   localparam int NSL_TMO_W          = 9;
   localparam logic [8:0] NSL_MASTER_TMO_CYC = 9'((NSL_MASTER_TMO_NS
      + NSL_CLK_PERIOD_NS - 1) / NSL_CLK_PERIOD_NS);
   localparam logic [8:0] NSL_CMD_TMO_CYC    = 9'((NSL_CMD_TMO_NS
      + NSL_CLK_PERIOD_NS - 1) / NSL_CLK_PERIOD_NS);

   // address match, shared by read and write decode
   function automatic logic nsl_port_hit(input logic [15:0] addr,
                                         input logic [15:0] port);
      nsl_port_hit = (addr == port);
   endfunction

endpackage
`default_nettype wire

// ### rtl/nsl_tmo_cnt.sv
`timescale 1ns/10ps
`default_nettype none
// counts cycles while i_run holds; o_expired once LIMIT cycles have passed
module nsl_tmo_cnt
   import nsl_pkg::*;
#(
   parameter logic [8:0] LIMIT = 9'h050
)(
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_ce,
   input  wire logic i_run,
   output var  logic o_expired
);

   logic [8:0] cnt_reg;   // elapsed cycles, saturating
   logic [8:0] cnt_next;

   // saturate so a stuck condition never wraps back to quiet
   always_comb begin
      cnt_next = cnt_reg;
      if (!i_run) begin
         cnt_next = 9'h000;
      end else if (cnt_reg != LIMIT) begin
         cnt_next = cnt_reg + 9'h001;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_reg <= 9'h000;
      end else if (i_ce) begin
         cnt_reg <= cnt_next;
      end
   end

   // level: stays high as long as the condition keeps going
   assign o_expired = (cnt_reg == LIMIT);

endmodule
`default_nettype wire

// ### rtl/nsl_rise_det.sv
`timescale 1ns/10ps
`default_nettype none
// one-cycle pulse on a low-to-high step of i_level
module nsl_rise_det (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_ce,
   input  wire logic i_level,
   output var  logic o_rise
);

   logic prev_reg;   // level seen last enabled cycle
   logic prev_next;

   always_comb begin
      prev_next = i_level;
   end

   // reset to high-free state so a level already high at reset is caught
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prev_reg <= 1'b0;
      end else if (i_ce) begin
         prev_reg <= prev_next;
      end
   end

   assign o_rise = i_level & ~prev_reg;

endmodule
`default_nettype wire

// ### rtl/nsl_nmi_src.sv
`timescale 1ns/10ps
`default_nettype none
module nsl_nmi_src
   import nsl_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_ce,
   input  wire logic [15:0] i_io_addr,
   input  wire logic        i_io_wr,
   input  wire logic        i_io_rd,
   input  wire logic [7:0]  i_io_wdata,
   input  wire logic        i_board_parity_n,
   input  wire logic        i_chan_check_n,
   input  wire logic        i_failsafe_out,
   input  wire logic        i_master_hold,
   input  wire logic        i_master_ack_n,
   input  wire logic        i_cpu_hold,
   input  wire logic        i_cmd_n,
   output var  logic [7:0]  o_io_rdata,
   output var  logic        o_io_ack,
   output var  logic        o_nmi,
   output var  logic        o_expansion_bus_reset_out,
   output var  logic        o_offender_reset_out
);

   // port decode
   logic wr_sys;    // write to system control port
   logic wr_mask;   // write to mask port
   logic wr_ext;    // write to extended control port
   logic wr_swt;    // write to software trigger port
   logic hit;       // any of the four ports addressed

   // software-visible state
   logic [3:0] sys_ctrl_reg;   // disable bits of system port
   logic [3:0] sys_ctrl_next;
   logic [3:0] ext_ctrl_reg;   // disable bits and bus reset bit
   logic [3:0] ext_ctrl_next;
   logic [7:0] mask_reg;       // global nmi mask port
   logic [7:0] mask_next;

   // source latches and timeout hold flags
   logic [4:0] pend_reg;       // one sticky bit per source
   logic [4:0] pend_next;
   logic [4:0] pend_set;
   logic [4:0] pend_clr;
   logic       bt_hold_reg;    // bus reset held by a timeout
   logic       bt_hold_next;
   logic       off_hold_reg;   // offending master reset held
   logic       off_hold_next;

   // outputs, registered
   logic [7:0] rdata_next;
   logic       ack_next;
   logic       nmi_next;
   logic       exp_rst_next;

   // event sources from the helper blocks
   logic fs_rise;       // fail-safe timer stepped high
   logic mt_expired;    // bus master overstayed
   logic cmd_expired;   // command strobe stuck active
   logic mt_run;

   // master timeout runs only for a bus master, never for the cpu
   assign mt_run = i_master_hold & i_master_ack_n & ~i_cpu_hold;

   nsl_rise_det u_fs_edge (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_ce    (i_ce),
      .i_level (i_failsafe_out),
      .o_rise  (fs_rise)
   );

   nsl_tmo_cnt #(.LIMIT(NSL_MASTER_TMO_CYC)) u_master_tmo (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_ce      (i_ce),
      .i_run     (mt_run),
      .o_expired (mt_expired)
   );

   nsl_tmo_cnt #(.LIMIT(NSL_CMD_TMO_CYC)) u_cmd_tmo (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_ce      (i_ce),
      .i_run     (~i_cmd_n),
      .o_expired (cmd_expired)
   );

   // address decode of the four ports
   always_comb begin
      wr_sys  = i_io_wr & nsl_port_hit(i_io_addr, NSL_SYS_CTRL_ADDR);
      wr_mask = i_io_wr & nsl_port_hit(i_io_addr, NSL_NMI_MASK_ADDR);
      wr_ext  = i_io_wr & nsl_port_hit(i_io_addr, NSL_EXT_CTRL_ADDR);
      wr_swt  = i_io_wr & nsl_port_hit(i_io_addr, NSL_SW_TRIG_ADDR);
      hit     = nsl_port_hit(i_io_addr, NSL_SYS_CTRL_ADDR)
              | nsl_port_hit(i_io_addr, NSL_NMI_MASK_ADDR)
              | nsl_port_hit(i_io_addr, NSL_EXT_CTRL_ADDR)
              | nsl_port_hit(i_io_addr, NSL_SW_TRIG_ADDR);
   end

   // control ports: plain stores; system and extended ports keep bits 3:0 of the written byte, the mask port the whole byte
   always_comb begin
      sys_ctrl_next = sys_ctrl_reg;
      ext_ctrl_next = ext_ctrl_reg;
      mask_next     = mask_reg;
      if (wr_sys) begin
         sys_ctrl_next = i_io_wdata[3:0];
      end
      if (wr_ext) begin
         ext_ctrl_next = i_io_wdata[3:0];
      end
      if (wr_mask) begin
         mask_next = i_io_wdata;
      end
   end

   // source latches; a source whose disable bit is high cannot set
   always_comb begin
      pend_set = 5'h00;
      pend_clr = 5'h00;
      pend_set[NSL_SRC_PAR] = ~i_board_parity_n
         & ~sys_ctrl_reg[NSL_SYS_PAR_DIS_BIT];
      pend_set[NSL_SRC_CHK] = ~i_chan_check_n
         & ~sys_ctrl_reg[NSL_SYS_CHK_DIS_BIT];
      pend_set[NSL_SRC_FS]  = fs_rise
         & ~ext_ctrl_reg[NSL_EXT_FS_DIS_BIT];
      pend_set[NSL_SRC_BT]  = (mt_expired | cmd_expired)
         & ~ext_ctrl_reg[NSL_EXT_BT_DIS_BIT];
      // any data works; the mask must be open for the trigger to count
      pend_set[NSL_SRC_SW]  = wr_swt & ~mask_reg[NSL_MASK_BIT]
         & ~ext_ctrl_reg[NSL_EXT_SW_DIS_BIT];
      // writing the enable/disable bit high clears the status
      pend_clr[NSL_SRC_PAR] = wr_sys & i_io_wdata[NSL_SYS_PAR_DIS_BIT];
      pend_clr[NSL_SRC_CHK] = wr_sys & i_io_wdata[NSL_SYS_CHK_DIS_BIT];
      pend_clr[NSL_SRC_FS]  = wr_ext & i_io_wdata[NSL_EXT_FS_DIS_BIT];
      pend_clr[NSL_SRC_BT]  = wr_ext & i_io_wdata[NSL_EXT_BT_DIS_BIT];
      pend_clr[NSL_SRC_SW]  = wr_ext & i_io_wdata[NSL_EXT_SW_DIS_BIT];
      // set beats clear so an event landing on the clear is kept;
      // reads never touch the latches
      pend_next = pend_set | (pend_reg & ~pend_clr);
   end

   // timeout hold flags keep the bus in reset until bit3 goes back to 0
   always_comb begin
      bt_hold_next  = bt_hold_reg;
      off_hold_next = off_hold_reg;
      if (wr_ext && !i_io_wdata[NSL_EXT_BT_DIS_BIT]) begin
         bt_hold_next  = 1'b0;
         off_hold_next = 1'b0;
      end
      if (pend_set[NSL_SRC_BT]) begin
         bt_hold_next = 1'b1;
      end
      if (mt_expired && !ext_ctrl_reg[NSL_EXT_BT_DIS_BIT]) begin
         off_hold_next = 1'b1;
      end
   end

   // outputs built from next values so nmi and reset rise together
   // with the latch that causes them, in the same edge
   always_comb begin
      nmi_next     = ~mask_next[NSL_MASK_BIT] & (|pend_next);
      exp_rst_next = ext_ctrl_next[NSL_EXT_BUS_RST_BIT]
                   | bt_hold_next;
   end

   // read mux; status bits first, unmapped and write-only read zero
   always_comb begin
      rdata_next = 8'h00;
      ack_next   = (i_io_rd | i_io_wr) & hit;
      if (i_io_rd) begin
         if (nsl_port_hit(i_io_addr, NSL_SYS_CTRL_ADDR)) begin
            rdata_next[3:0] = sys_ctrl_reg;
            rdata_next[NSL_SYS_PAR_STS_BIT] = pend_reg[NSL_SRC_PAR];
            rdata_next[NSL_SYS_CHK_STS_BIT] = pend_reg[NSL_SRC_CHK];
         end else if (nsl_port_hit(i_io_addr, NSL_NMI_MASK_ADDR)) begin
            rdata_next = mask_reg;
         end else if (nsl_port_hit(i_io_addr, NSL_EXT_CTRL_ADDR)) begin
            rdata_next[3:0] = ext_ctrl_reg;
            rdata_next[NSL_EXT_FS_STS_BIT] = pend_reg[NSL_SRC_FS];
            rdata_next[NSL_EXT_BT_STS_BIT] = pend_reg[NSL_SRC_BT];
            rdata_next[NSL_EXT_SW_STS_BIT] = pend_reg[NSL_SRC_SW];
         end else begin
            rdata_next = 8'h00;
         end
      end
   end

   // single register stage for all state; ce low freezes everything
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sys_ctrl_reg              <= NSL_SYS_CTRL_RST;
         ext_ctrl_reg              <= NSL_EXT_CTRL_RST;
         mask_reg                  <= NSL_NMI_MASK_RST;
         pend_reg                  <= NSL_PEND_RST;
         bt_hold_reg               <= 1'b0;
         off_hold_reg              <= 1'b0;
         o_io_rdata                <= 8'h00;
         o_io_ack                  <= 1'b0;
         o_nmi                     <= 1'b0;
         o_expansion_bus_reset_out <= 1'b0;
         o_offender_reset_out      <= 1'b0;
      end else if (i_ce) begin
         sys_ctrl_reg              <= sys_ctrl_next;
         ext_ctrl_reg              <= ext_ctrl_next;
         mask_reg                  <= mask_next;
         pend_reg                  <= pend_next;
         bt_hold_reg               <= bt_hold_next;
         off_hold_reg              <= off_hold_next;
         o_io_rdata                <= rdata_next;
         o_io_ack                  <= ack_next;
         o_nmi                     <= nmi_next;
         o_expansion_bus_reset_out <= exp_rst_next;
         o_offender_reset_out      <= off_hold_next;
      end
   end

   // checks on the logic above; ce low parks them
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n || !i_ce);

   par_latch_a: assert property (
      !i_board_parity_n && !sys_ctrl_reg[NSL_SYS_PAR_DIS_BIT]
      |=> pend_reg[NSL_SRC_PAR]) else $error("parity not latched");

   chk_latch_a: assert property (
      !i_chan_check_n && !sys_ctrl_reg[NSL_SYS_CHK_DIS_BIT]
      |=> pend_reg[NSL_SRC_CHK]) else $error("channel check not latched");

   fs_edge_a: assert property (
      $rose(i_failsafe_out) && !ext_ctrl_reg[NSL_EXT_FS_DIS_BIT]
      |=> pend_reg[NSL_SRC_FS]) else $error("fail-safe edge lost");

   // helper: enabled run cycles in a row, counted apart from the timer
   // so a broken timer cannot hide behind its own count
   logic [8:0] mt_age_reg;   // consecutive run cycles, saturating
   logic [8:0] mt_age_next;
   always_comb begin
      mt_age_next = 9'h000;
      if (mt_run && !ext_ctrl_reg[NSL_EXT_BT_DIS_BIT]) begin
         mt_age_next = mt_age_reg + {8'h00, mt_age_reg != 9'h1FF};
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mt_age_reg <= 9'h000;
      end else if (i_ce) begin
         mt_age_reg <= mt_age_next;
      end
   end

   mt_reset_a: assert property (
      mt_age_reg >= NSL_MASTER_TMO_CYC && !ext_ctrl_reg[NSL_EXT_BT_DIS_BIT]
      |=> o_expansion_bus_reset_out && o_offender_reset_out
          && pend_reg[NSL_SRC_BT]) else $error("master timeout missed");

   cpu_quiet_a: assert property (
      i_cpu_hold && $past(i_cpu_hold) |-> !mt_expired)
      else $error("timeout while cpu holds bus");

   cmd_tmo_a: assert property (
      cmd_expired && !ext_ctrl_reg[NSL_EXT_BT_DIS_BIT]
      |=> o_expansion_bus_reset_out && pend_reg[NSL_SRC_BT])
      else $error("command timeout missed");

   rst_hold_a: assert property (
      bt_hold_reg && !(wr_ext && !i_io_wdata[NSL_EXT_BT_DIS_BIT])
      |=> o_expansion_bus_reset_out) else $error("bus reset dropped early");

   sw_trig_a: assert property (
      wr_swt && !mask_reg[NSL_MASK_BIT] && !wr_mask
      && !ext_ctrl_reg[NSL_EXT_SW_DIS_BIT]
      |=> o_nmi && pend_reg[NSL_SRC_SW]) else $error("trigger gave no nmi");

   sys_read_a: assert property (
      i_io_rd && nsl_port_hit(i_io_addr, NSL_SYS_CTRL_ADDR)
      |=> o_io_rdata[7:6] == {$past(pend_reg[NSL_SRC_PAR]),
                              $past(pend_reg[NSL_SRC_CHK])} && o_io_ack)
      else $error("system port status wrong");

   ext_read_a: assert property (
      i_io_rd && nsl_port_hit(i_io_addr, NSL_EXT_CTRL_ADDR)
      |=> o_io_rdata[7:5] == {$past(pend_reg[NSL_SRC_FS]),
          $past(pend_reg[NSL_SRC_BT]), $past(pend_reg[NSL_SRC_SW])})
      else $error("extended port status wrong");

   par_clear_a: assert property (
      wr_sys && i_io_wdata[NSL_SYS_PAR_DIS_BIT] && i_board_parity_n
      |=> !pend_reg[NSL_SRC_PAR]) else $error("parity status not cleared");

   mask_gate_a: assert property (
      mask_reg[NSL_MASK_BIT] |-> !o_nmi) else $error("nmi through mask");

   mask_reedge_a: assert property (
      $fell(mask_reg[NSL_MASK_BIT]) && (|pend_reg) |-> o_nmi)
      else $error("no fresh nmi edge after mask toggle");

   sw_bus_rst_a: assert property (
      ext_ctrl_reg[NSL_EXT_BUS_RST_BIT] |-> o_expansion_bus_reset_out)
      else $error("software bus reset not driven");

   nmi_or_a: assert property (
      !mask_reg[NSL_MASK_BIT] && (|pend_reg) |-> o_nmi)
      else $error("pending source without nmi");

   read_keep_a: assert property (
      i_io_rd && !i_io_wr |=> (pend_reg & $past(pend_reg)) == $past(pend_reg))
      else $error("read disturbed status");

   nmi_rise_c:   cover property ($rose(o_nmi));
   bt_reset_c:   cover property ($rose(bt_hold_reg));
   sw_nmi_c:     cover property (wr_swt ##1 o_nmi);
   mask_retry_c: cover property (o_nmi ##1 !o_nmi ##[1:8] o_nmi);

endmodule
`default_nettype wire

// ### dv/nsl_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// host cpu side: one-cycle strobed port accesses, answer taken next cycle
module nsl_host_model
   import nsl_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic [7:0]  i_io_rdata,
   input  wire logic        i_io_ack,
   output var  logic [15:0] o_io_addr,
   output var  logic        o_io_wr,
   output var  logic        o_io_rd,
   output var  logic [7:0]  o_io_wdata
);
   // idle bus parked off every mapped port
   initial begin
      o_io_addr  = 16'hFFFF;
      o_io_wr    = 1'b0;
      o_io_rd    = 1'b0;
      o_io_wdata = 8'h00;
   end

   // strobe stands for one edge; released lines show inverted values
   task automatic access(input logic [15:0] a, input logic w,
                         input logic [7:0] d, output logic [7:0] r,
                         output logic k);
      @(posedge i_clk);
      #1;
      o_io_addr  = a;
      o_io_wr    = w;
      o_io_rd    = !w;
      o_io_wdata = d;
      @(posedge i_clk);
      #1;
      r          = i_io_rdata;
      k          = i_io_ack;
      o_io_wr    = 1'b0;
      o_io_rd    = 1'b0;
      o_io_addr  = ~a;
      o_io_wdata = ~d;
   endtask

   // nmi handler: read both status ports, clear, then toggle the mask
   task automatic service(output logic [7:0] sys, output logic [7:0] ext);
      logic [7:0] r;
      logic       k;
      access(NSL_SYS_CTRL_ADDR, 1'b0, 8'h00, sys, k);
      access(NSL_EXT_CTRL_ADDR, 1'b0, 8'h00, ext, k);
      access(NSL_SYS_CTRL_ADDR, 1'b1, {4'h0, sys[6], sys[7], 2'h0}, r, k);
      access(NSL_EXT_CTRL_ADDR, 1'b1,
             {4'h0, ext[6], ext[7], ext[5], 1'b0}, r, k);
      access(NSL_SYS_CTRL_ADDR, 1'b1, 8'h00, r, k);
      access(NSL_EXT_CTRL_ADDR, 1'b1, 8'h00, r, k);
      // mask high then low gives the cpu a fresh edge if more is pending
      access(NSL_NMI_MASK_ADDR, 1'b1, 8'h80, r, k);
      access(NSL_NMI_MASK_ADDR, 1'b1, 8'h00, r, k);
   endtask
endmodule
`default_nettype wire

// ### dv/nsl_nmi_src_tb.sv
`timescale 1ns/10ps
`default_nettype none
module nsl_nmi_src_tb;
   import nsl_pkg::*;
   logic        clk;               // 10 MHz bus clock
   logic        rst_n;             // async reset, active low
   logic [15:0] addr;              // host address
   logic        wr;                // host write strobe
   logic        rd;                // host read strobe
   logic [7:0]  wdata;             // host write data
   logic [7:0]  rdata;             // port read data
   logic        ack;               // port answer
   logic        par_n;             // board parity error, low active
   logic        chk_n;             // channel check, low active
   logic        fs;                // fail-safe timer output
   logic        m_hold;            // bus master owns the bus
   logic        m_ack_n;           // master acknowledge, high withdrawn
   logic        cpu_hold;          // cpu owns the bus
   logic        cmd_n;             // command strobe, low active
   logic        nmi;               // nmi to the cpu
   logic        bus_rst;           // expansion bus reset
   logic        off_rst;           // offender reset
   int          num_errors;        // mismatches
   int          samples_checked;   // comparisons
   int          cyc_cnt;           // hang guard
   logic [31:0] seed;              // xorshift state
   logic [7:0]  s_sys;             // handler view of system port
   logic [7:0]  s_ext;             // handler view of extended port

   nsl_nmi_src nsl_nmi_src_i (
      .i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_io_addr(addr),
      .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wdata),
      .i_board_parity_n(par_n), .i_chan_check_n(chk_n),
      .i_failsafe_out(fs), .i_master_hold(m_hold),
      .i_master_ack_n(m_ack_n), .i_cpu_hold(cpu_hold), .i_cmd_n(cmd_n),
      .o_io_rdata(rdata), .o_io_ack(ack), .o_nmi(nmi),
      .o_expansion_bus_reset_out(bus_rst), .o_offender_reset_out(off_rst)
   );

   nsl_host_model nsl_host_model_i (
      .i_clk(clk), .i_io_rdata(rdata), .i_io_ack(ack), .o_io_addr(addr),
      .o_io_wr(wr), .o_io_rd(rd), .o_io_wdata(wdata)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
   endfunction

   task automatic summarize();
      if (num_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input string n, input logic [7:0] s,
                        input logic [7:0] e);
      samples_checked++;
      if (s !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask

   // outputs as one byte: {nmi, bus reset, offender reset}
   function automatic logic [7:0] outs();
      outs = {5'h00, nmi, bus_rst, off_rst};
   endfunction

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr_p(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic       k;
      nsl_host_model_i.access(a, 1'b1, d, r, k);
      check("write ack", {7'h00, k}, 8'h01);
   endtask

   task automatic rd_chk(input string n, input logic [15:0] a,
                         input logic [7:0] e, input logic ek);
      logic [7:0] r;
      logic       k;
      nsl_host_model_i.access(a, 1'b0, 8'h00, r, k);
      check(n, r, e);
      check("read ack", {7'h00, k}, {7'h00, ek});
   endtask

   // one-edge parity and check pulses, fail-safe a lasting step
   task automatic drive_src(input int i, input logic v);
      if (i == 0) par_n = !v;
      else if (i == 1) chk_n = !v;
      else fs = v;
   endtask

   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 4000) begin
         num_errors++;
         summarize();
      end
   end

   initial begin
      logic [15:0] port [3];
      logic [7:0]  sts [3];
      logic [7:0]  dis [3];
      port = '{NSL_SYS_CTRL_ADDR, NSL_SYS_CTRL_ADDR, NSL_EXT_CTRL_ADDR};
      sts  = '{8'h80, 8'h40, 8'h80};
      dis  = '{8'h04, 8'h08, 8'h04};
      num_errors = 0;
      samples_checked = 0;
      cyc_cnt = 0;
      seed = 32'ha9b05e4e;
      rst_n = 1'b0;
      {par_n, chk_n, m_ack_n, cmd_n} = 4'hF;
      {fs, m_hold, cpu_hold} = 3'h0;
      step(12);
      rst_n = 1'b1;
      // reset values, then unmapped and write-only places
      check("outputs after reset", outs(), 8'h00);
      rd_chk("sys reset", NSL_SYS_CTRL_ADDR, 8'h00, 1'b1);
      rd_chk("mask reset", NSL_NMI_MASK_ADDR, 8'h80, 1'b1);
      rd_chk("ext reset", NSL_EXT_CTRL_ADDR, 8'h00, 1'b1);
      rd_chk("trigger read", NSL_SW_TRIG_ADDR, 8'h00, 1'b1);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         rd_chk("unmapped", {4'hA, seed[11:0]}, 8'h00, 1'b0);
         wr_p(NSL_NMI_MASK_ADDR, seed[23:16]);
         rd_chk("mask rw", NSL_NMI_MASK_ADDR, seed[23:16], 1'b1);
      end
      wr_p(NSL_NMI_MASK_ADDR, 8'h00);
      // hardware sources: latch, report, hold over reads, clear
      for (int i = 0; i < 3; i++) begin
         drive_src(i, 1'b1);
         step(1);
         if (i < 2) drive_src(i, 1'b0);
         check("nmi on source", outs(), 8'h04);
         rd_chk("status", port[i], sts[i], 1'b1);
         rd_chk("status held", port[i], sts[i], 1'b1);
         wr_p(port[i], dis[i]);
         wr_p(port[i], 8'h00);
         rd_chk("status cleared", port[i], 8'h00, 1'b1);
         check("nmi cleared", outs(), 8'h00);
      end
      fs = 1'b0;
      // mask gating and the fresh edge
      chk_n = 1'b0;
      step(1);
      chk_n = 1'b1;
      wr_p(NSL_NMI_MASK_ADDR, 8'h80);
      check("masked nmi", outs(), 8'h00);
      wr_p(NSL_NMI_MASK_ADDR, 8'h00);
      check("unmasked nmi", outs(), 8'h04);
      nsl_host_model_i.service(s_sys, s_ext);
      check("handler sys", s_sys, 8'h40);
      check("nmi after handler", outs(), 8'h00);
      // software trigger, unmasked then masked
      seed = xs(seed);
      wr_p(NSL_SW_TRIG_ADDR, seed[7:0]);
      check("trigger nmi", outs(), 8'h04);
      nsl_host_model_i.service(s_sys, s_ext);
      check("handler ext", s_ext, 8'h20);
      wr_p(NSL_NMI_MASK_ADDR, 8'h80);
      wr_p(NSL_SW_TRIG_ADDR, seed[15:8]);
      wr_p(NSL_NMI_MASK_ADDR, 8'h00);
      check("masked trigger", outs(), 8'h00);
      // cpu or acknowledged master holding never times out
      {m_hold, cpu_hold} = 2'h3;
      step(120);
      m_ack_n = 1'b0;
      cpu_hold = 1'b0;
      step(120);
      check("no master timeout", outs(), 8'h00);
      // master overstay after acknowledge withdrawn
      m_ack_n = 1'b1;
      step(79);
      check("before master limit", outs(), 8'h00);
      step(3);
      check("master timeout", outs(), 8'h07);
      m_hold = 1'b0;
      step(5);
      rd_chk("timeout status", NSL_EXT_CTRL_ADDR, 8'h40, 1'b1);
      wr_p(NSL_EXT_CTRL_ADDR, 8'h08);
      check("reset held", {7'h00, bus_rst}, 8'h01);
      wr_p(NSL_EXT_CTRL_ADDR, 8'h00);
      check("reset released", outs(), 8'h00);
      // command strobe active too long
      cmd_n = 1'b0;
      step(318);
      check("before command limit", outs(), 8'h00);
      step(4);
      check("command timeout", outs(), 8'h06);
      cmd_n = 1'b1;
      wr_p(NSL_EXT_CTRL_ADDR, 8'h08);
      wr_p(NSL_EXT_CTRL_ADDR, 8'h00);
      check("command reset released", outs(), 8'h00);
      // software-held expansion bus reset, held a while then dropped
      wr_p(NSL_EXT_CTRL_ADDR, 8'h01);
      step(10);
      check("soft bus reset", outs(), 8'h02);
      rd_chk("soft reset bit", NSL_EXT_CTRL_ADDR, 8'h01, 1'b1);
      wr_p(NSL_EXT_CTRL_ADDR, 8'h00);
      check("soft reset off", outs(), 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
